// ==== alarm_queue.sv ====
// Purpose: Consecutive-fault counter and alarm pin driver
// Assumes: One sample pulse per finished conversion
// Notes:   fault means the result lies outside the limits
`timescale 1ns/1ps
module alarm_queue import temp_cfg_pkg::*; (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       sample,
	input wire logic       fault,
	input wire logic       clear_count,
	input wire logic       service,
	input wire logic [1:0] queue_sel,
	input wire logic       int_mode,
	input wire logic       polarity,
	output logic           alert_pin
);
	logic [2:0] count_reg;
	logic [2:0] count_next;
	logic [2:0] thr;
	logic       cmp_reg;
	logic       int_reg;
	logic       active;

	assign thr        = fault_threshold(queue_sel);
	assign count_next = (count_reg < thr) ? count_reg + 3'h1 : count_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n || clear_count) begin
			count_reg <= 3'h0;
		end else if (sample) begin
			count_reg <= fault ? count_next : 3'h0;
		end
	end

	// Comparator follows each sample; interrupt latches until serviced
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmp_reg <= 1'b0;
			int_reg <= 1'b0;
		end else begin
			if (sample) begin
				cmp_reg <= fault && (count_next >= thr);
			end
			// Set wins over a same-cycle service
			if (sample && fault && count_reg < thr && count_next >= thr) begin
				int_reg <= 1'b1;
			end else if (service) begin
				int_reg <= 1'b0;
			end
		end
	end

	assign active = int_mode ? int_reg : cmp_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			alert_pin <= 1'b1;
		end else begin
			alert_pin <= polarity ? active : ~active;
		end
	end
endmodule

// ==== nv_port_if.sv ====
// Purpose: Program request and stored value between register logic and store
// Assumes: One clock domain
// Notes:   prog_req is a one-cycle pulse
`timescale 1ns/1ps
interface nv_port_if;
	logic        prog_req;
	logic [15:0] prog_data;
	logic [15:0] stored;
	logic        busy;
	modport owner (input prog_req, input prog_data, output stored, output busy);
	modport user  (output prog_req, output prog_data, input stored, input busy);
endinterface

// ==== nv_store.sv ====
// Purpose: Stored configuration word with self-timed programming
// Assumes: factory_init_n models the array's factory state only
// Notes:   Contents survive rst_n; a program cut by rst_n is lost
`timescale 1ns/1ps
module nv_store import temp_cfg_pkg::*; #(
	parameter int PROG_CYCLES = NV_PROG_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic factory_init_n,
	nv_port_if.owner port
);
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	logic [15:0]      stored_reg;
	logic [15:0]      pend_reg;
	logic [15:0]      pend_next;
	logic             busy_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             done;

	// ==================================================================
	// Lock filtering of a requested value
	always_comb begin
		pend_next = port.prog_data & STORED_MASK;
		if (stored_reg[BIT_RLOCK]) begin
			pend_next = stored_reg;
			pend_next[BIT_RLOCK] = port.prog_data[BIT_RLOCK];
		end
	end

	// ==================================================================
	// Program timer
	assign done = busy_reg && (cnt_reg == '0);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			cnt_reg  <= '0;
			pend_reg <= STORED_FACTORY;
		end else if (port.prog_req && !busy_reg && !stored_reg[BIT_LOCKDOWN]) begin
			busy_reg <= 1'b1;
			cnt_reg  <= CNT_W'(PROG_CYCLES - 1);
			pend_reg <= pend_next;
		end else if (done) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// ==================================================================
	// Storage cells, not touched by rst_n
	always_ff @(posedge core_clk) begin
		if (!factory_init_n) begin
			stored_reg <= STORED_FACTORY;
		end else if (done) begin
			stored_reg <= pend_reg;
			stored_reg[BIT_LOCKDOWN] <= pend_reg[BIT_LOCKDOWN] | stored_reg[BIT_LOCKDOWN];
		end
	end

	assign port.stored = stored_reg;
	assign port.busy   = busy_reg;
endmodule

// ==== temp_bus_host.sv ====
// Purpose: Two-wire host model driving the configuration block's bus
// Assumes: Open-drain data line with pull-up, host owns the clock line
// Notes:   Bit of ten core clocks, clock high for four; clock line idles high
`timescale 1ns/1ps
module temp_bus_host (
	input wire logic core_clk,
	input wire logic dev_oe,
	output logic     scl,
	output logic     sda
);
	logic host_oe = 1'b0;
	initial scl = 1'b1;
	// Released line floats to the pull-up level
	assign sda = !(host_oe || dev_oe);

	task automatic hold(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Also serves as repeated start when entered with the clock low
	task automatic start();
		host_oe = 1'b0;
		hold(4);
		scl = 1'b1;
		hold(4);
		host_oe = 1'b1;
		hold(4);
		scl = 1'b0;
		hold(2);
	endtask
	task automatic stop();
		host_oe = 1'b1;
		hold(4);
		scl = 1'b1;
		hold(4);
		host_oe = 1'b0;
		hold(8);
	endtask
	task automatic xfer(input logic b, output logic r);
		host_oe = !b;
		hold(4);
		scl = 1'b1;
		hold(2);
		r = sda;
		hold(2);
		scl = 1'b0;
		hold(2);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xfer(d[i], r);
		xfer(1'b1, r);
		ack = !r;
	endtask
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, r);
			d[i] = r;
		end
		xfer(last, r);
	endtask
endmodule

// ==== temp_cfg_pkg.sv ====
// Purpose: Shared constants and types of the sensor configuration block
// Assumes: 100 MHz core clock, synchronous pin inputs
// Notes:   Field positions are bit indices of the 16-bit configuration words
// =====================================================================
// Overview of operation
// - Fault queue code 00/01/10/11 needs 1/2/4/6 consecutive faults before alarm.
// - Reset loads the working fault queue field from its stored default.
// - Alarm pin is active low when polarity is 0, active high when 1.
// - Reset loads the working alarm polarity from its stored default.
// - Mode bit 0 gives comparator alarm behaviour, 1 gives interrupt behaviour.
// - Reset loads the comparator/interrupt selection from its stored default.
// - With shutdown bit 0, conversions run continuously back to back.
// - Setting shutdown finishes the running conversion, stores it, then halts.
// - Clearing shutdown resumes continuous conversions.
// - Reset loads the shutdown bit from its stored default.
// - Busy flag reads 1 while stored registers program, otherwise 0.
// - Writes to stored registers while busy are discarded.
// - Both copy commands are ignored while busy.
// - Stored configuration is 16 bits, read/write, kept through reset.
// - Reset copies stored bits 15:8 into the working register.
// - Stored bits 14:13 hold default resolution, 00 is 9 bits.
// - Stored bits 12:11 hold default fault queue, factory 00.
// - Stored bits 10, 9, 8 hold default polarity, mode, shutdown; factory 0.
// - Stored bit 2 set permanently locks all configuration registers.
// - Stored bit 1 set locks configuration registers; 0 leaves them writable.
// - Stored bits 15, 7:3 and 0 always read 0; the code reads the whole stored register as FFh bytes while busy.
// - Stored write is pointer 11h plus two bytes, programmed only on stop.
// - Repeated start ending a stored write aborts it, register unchanged.
// - While bit 1 locks, only clearing the lock bit of stored register is allowed.
// - Each accepted working register write clears the fault counter.
package temp_cfg_pkg;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam logic [3:0]  DEV_ADDR_HI     = 4'h9;
	localparam logic [7:0]  PTR_WORK_CFG    = 8'h01;
	localparam logic [7:0]  PTR_STORED_CFG  = 8'h11;
	localparam logic [7:0]  CMD_COPY_TO_NV  = 8'hc0;
	localparam logic [7:0]  CMD_COPY_FROM_NV = 8'hc1;
	localparam logic [7:0]  INVALID_BYTE    = 8'hff;
	localparam int          BIT_RES_LO      = 13;
	localparam int          BIT_FQ_LO       = 11;
	localparam int          BIT_POL         = 10;
	localparam int          BIT_MODE        = 9;
	localparam int          BIT_SD          = 8;
	localparam int          BIT_LOCKDOWN    = 2;
	localparam int          BIT_RLOCK       = 1;
	localparam int          BIT_BUSY        = 0;
	localparam logic [15:0] STORED_MASK     = 16'h7f06;
	localparam logic [15:0] STORED_FACTORY  = 16'h0000;
	localparam logic [7:0]  WORK_MASK       = 8'h7f;
	localparam int          NV_PROG_TIME_US = 10;
	localparam int          NV_PROG_CYCLES  = NV_PROG_TIME_US * 1000 / CLK_PERIOD_NS;

	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_WRITE, L_ACK, L_READ, L_MACK} link_state_type;
	typedef enum logic       {C_HALT, C_RUN} conv_state_type;

	function automatic logic [2:0] fault_threshold(input logic [1:0] sel);
		case (sel)
			2'b00:   fault_threshold = 3'h1;
			2'b01:   fault_threshold = 3'h2;
			2'b10:   fault_threshold = 3'h4;
			default: fault_threshold = 3'h6;
		endcase
	endfunction
endpackage

// ==== temp_sensor_config_regs.sv ====
// Purpose: Two-wire register slave for working and stored configuration
// Assumes: scl_in and sda_in already synchronous to core_clk
// Notes:   sda is open drain; sda_oe high pulls the line low
`timescale 1ns/1ps
module temp_sensor_config_regs import temp_cfg_pkg::*; #(
	parameter int PROG_CYCLES = NV_PROG_CYCLES
) (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       factory_init_n,
	input wire logic [2:0] addr_pins,
	input wire logic       scl_in,
	input wire logic       sda_in,
	output logic           sda_out,
	output logic           sda_oe,
	input wire logic       conv_done,
	input wire logic       conv_fault,
	output logic           conv_start,
	output logic           result_store,
	output logic           in_shutdown,
	output logic [1:0]     resolution_sel,
	output logic           alert_pin,
	output logic           nv_busy_flag
);
	nv_port_if nv ();

	link_state_type link_state_reg;
	conv_state_type conv_state_reg;

	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic       rd_mode_reg;
	logic       sda_drive_reg;

	logic [7:0]  ptr_reg;
	logic        got_ptr_reg;
	logic [1:0]  data_cnt_reg;
	logic        cmd_armed_reg;
	logic [15:0] nv_buf_reg;
	logic        rd_index_reg;
	logic [7:0]  work_reg;
	logic        fault_sample_reg;

	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       byte_end;
	logic       addr_match;
	logic       addr_hit;
	logic       byte_nack;
	logic       byte_rx;
	logic       tx_take;
	logic [7:0] tx_byte;
	logic       locked;
	logic       cfg_write;
	logic       stop_commit;
	logic       copy_to_nv;
	logic       copy_from_nv;

	// ==================================================================
	// Bus conditions
	assign scl_rise  = scl_in && !scl_prev_reg;
	assign scl_fall  = !scl_in && scl_prev_reg;
	assign bus_start = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
	assign bus_stop  = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
		end
	end

	// ==================================================================
	// Byte-level events
	assign byte_end   = scl_fall && (bit_cnt_reg == 4'h8);
	assign addr_match = (shift_reg[7:1] == {DEV_ADDR_HI, addr_pins});
	assign addr_hit   = byte_end && (link_state_reg == L_ADDR) && addr_match;
	// Data to the stored register is refused outright while programming
	assign byte_nack  = got_ptr_reg && (ptr_reg == PTR_STORED_CFG) && nv.busy;
	assign byte_rx    = byte_end && (link_state_reg == L_WRITE) && !byte_nack;
	assign tx_take    = scl_fall && ((link_state_reg == L_ACK && rd_mode_reg)
	                    || link_state_reg == L_MACK);

	// ==================================================================
	// Bit engine
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			link_state_reg <= L_IDLE;
			shift_reg      <= 8'h00;
			bit_cnt_reg    <= 4'h0;
			rd_mode_reg    <= 1'b0;
			sda_drive_reg  <= 1'b0;
		end else if (bus_start) begin
			link_state_reg <= L_ADDR;
			bit_cnt_reg    <= 4'h0;
			sda_drive_reg  <= 1'b0;
		end else if (bus_stop) begin
			link_state_reg <= L_IDLE;
			sda_drive_reg  <= 1'b0;
		end else begin
			case (link_state_reg)
				L_IDLE: begin
					sda_drive_reg <= 1'b0;
				end
				L_ADDR, L_WRITE: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_in};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_end) begin
						if (link_state_reg == L_ADDR && !addr_match) begin
							link_state_reg <= L_IDLE;
						end else if (link_state_reg == L_WRITE && byte_nack) begin
							link_state_reg <= L_IDLE;
						end else begin
							link_state_reg <= L_ACK;
							sda_drive_reg  <= 1'b1;
							if (link_state_reg == L_ADDR) begin
								rd_mode_reg <= shift_reg[0];
							end
						end
					end
				end
				L_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (rd_mode_reg) begin
							shift_reg      <= tx_byte;
							sda_drive_reg  <= ~tx_byte[7];
							link_state_reg <= L_READ;
						end else begin
							sda_drive_reg  <= 1'b0;
							link_state_reg <= L_WRITE;
						end
					end
				end
				L_READ: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							sda_drive_reg  <= 1'b0;
							link_state_reg <= L_MACK;
						end else begin
							shift_reg     <= {shift_reg[6:0], 1'b0};
							sda_drive_reg <= ~shift_reg[6];
							bit_cnt_reg   <= bit_cnt_reg + 4'h1;
						end
					end
				end
				L_MACK: begin
					// Host not acknowledging ends the read
					if (scl_rise && sda_in) begin
						link_state_reg <= L_IDLE;
					end else if (scl_fall) begin
						bit_cnt_reg    <= 4'h0;
						shift_reg      <= tx_byte;
						sda_drive_reg  <= ~tx_byte[7];
						link_state_reg <= L_READ;
					end
				end
				default: begin
					link_state_reg <= L_IDLE;
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = sda_drive_reg;

	// ==================================================================
	// Read data
	always_comb begin
		tx_byte = 8'h00;
		case (ptr_reg)
			PTR_WORK_CFG: begin
				tx_byte = rd_index_reg ? {7'h00, nv.busy} : work_reg;
			end
			PTR_STORED_CFG: begin
				if (nv.busy) begin
					tx_byte = INVALID_BYTE;
				end else begin
					tx_byte = rd_index_reg ? nv.stored[7:0] : nv.stored[15:8];
				end
			end
			default: begin
				tx_byte = 8'h00;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || addr_hit) begin
			rd_index_reg <= 1'b0;
		end else if (tx_take) begin
			rd_index_reg <= 1'b1;
		end
	end

	// ==================================================================
	// Write transaction tracking
	assign locked       = nv.stored[BIT_RLOCK] || nv.stored[BIT_LOCKDOWN];
	assign cfg_write    = byte_rx && got_ptr_reg && (ptr_reg == PTR_WORK_CFG)
	                      && (data_cnt_reg == 2'h0) && !locked;
	// Stop alone commits; a repeated start has already cleared the count
	assign stop_commit  = bus_stop && got_ptr_reg && (ptr_reg == PTR_STORED_CFG)
	                      && (data_cnt_reg == 2'h2) && !nv.busy;
	assign copy_to_nv   = bus_stop && cmd_armed_reg && (ptr_reg == CMD_COPY_TO_NV)
	                      && !nv.busy && !locked;
	assign copy_from_nv = bus_stop && cmd_armed_reg && (ptr_reg == CMD_COPY_FROM_NV)
	                      && !nv.busy && !locked;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ptr_reg       <= 8'h00;
			got_ptr_reg   <= 1'b0;
			data_cnt_reg  <= 2'h0;
			cmd_armed_reg <= 1'b0;
			nv_buf_reg    <= 16'h0000;
		end else if (bus_start || bus_stop) begin
			got_ptr_reg   <= 1'b0;
			data_cnt_reg  <= 2'h0;
			cmd_armed_reg <= 1'b0;
		end else if (byte_rx) begin
			if (!got_ptr_reg) begin
				ptr_reg       <= shift_reg;
				got_ptr_reg   <= 1'b1;
				cmd_armed_reg <= (shift_reg == CMD_COPY_TO_NV) || (shift_reg == CMD_COPY_FROM_NV);
			end else begin
				cmd_armed_reg <= 1'b0;
				if (data_cnt_reg == 2'h0) begin
					nv_buf_reg[15:8] <= shift_reg;
				end else if (data_cnt_reg == 2'h1) begin
					nv_buf_reg[7:0] <= shift_reg;
				end
				// Bytes past the second are dropped
				if (data_cnt_reg != 2'h2) begin
					data_cnt_reg <= data_cnt_reg + 2'h1;
				end
			end
		end
	end

	assign nv.prog_req  = stop_commit || copy_to_nv;
	assign nv.prog_data = copy_to_nv ? {work_reg, nv.stored[7:0]} : nv_buf_reg;

	// ==================================================================
	// Working configuration, reloaded from the stored upper byte on reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			work_reg <= nv.stored[15:8] & WORK_MASK;
		end else if (cfg_write) begin
			work_reg <= shift_reg & WORK_MASK;
		end else if (copy_from_nv) begin
			work_reg <= nv.stored[15:8] & WORK_MASK;
		end
	end

	assign resolution_sel = work_reg[BIT_RES_LO-8 +: 2];
	assign nv_busy_flag   = nv.busy;

	// ==================================================================
	// Conversion sequencing
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			conv_state_reg <= C_HALT;
			conv_start     <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			case (conv_state_reg)
				C_HALT: begin
					if (!work_reg[BIT_SD-8]) begin
						conv_start     <= 1'b1;
						conv_state_reg <= C_RUN;
					end
				end
				C_RUN: begin
					if (conv_done) begin
						if (work_reg[BIT_SD-8]) begin
							conv_state_reg <= C_HALT;
						end else begin
							conv_start <= 1'b1;
						end
					end
				end
				default: begin
					conv_state_reg <= C_HALT;
				end
			endcase
		end
	end

	// Result is stored even when shutdown was requested mid-conversion
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_store     <= 1'b0;
			fault_sample_reg <= 1'b0;
		end else begin
			result_store     <= conv_done && (conv_state_reg == C_RUN);
			fault_sample_reg <= conv_fault;
		end
	end

	assign in_shutdown = (conv_state_reg == C_HALT);

	// ==================================================================
	// Leaves
	nv_store #(.PROG_CYCLES(PROG_CYCLES)) u_store (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.factory_init_n (factory_init_n),
		.port           (nv.owner)
	);

	alarm_queue u_alarm (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.sample      (result_store),
		.fault       (fault_sample_reg),
		.clear_count (cfg_write),
		.service     (tx_take),
		.queue_sel   (work_reg[BIT_FQ_LO-8 +: 2]),
		.int_mode    (work_reg[BIT_MODE-8]),
		.polarity    (work_reg[BIT_POL-8]),
		.alert_pin   (alert_pin)
	);
endmodule

// ==== temp_sensor_config_regs_bench.sv ====
// Purpose: Self-checking bench for the configuration block
// Assumes: Inputs driven at the falling edge of core_clk
// Notes:   Program time lengthened to 1200 cycles, long enough for a busy-time transfer
`timescale 1ns/1ps
module temp_sensor_config_regs_bench import temp_cfg_pkg::*;;
	localparam int         PROG = 1200;
	localparam logic [2:0] PINS = 3'h5;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        factory_init_n = 1'b0;
	logic        conv_done = 1'b0;
	logic        conv_fault = 1'b0;
	logic        scl, sda, sda_out, sda_oe, conv_start, result_store;
	logic        in_shutdown, alert_pin, nv_busy_flag;
	logic [1:0]  resolution_sel;
	int          err_count = 0;
	int          checks = 0;
	int          starts = 0;

	always #5 core_clk = !core_clk;
	always @(posedge core_clk) if (conv_start === 1'b1) starts++;

	temp_bus_host i_temp_bus_host (.core_clk(core_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
	temp_sensor_config_regs #(.PROG_CYCLES(PROG)) i_temp_sensor_config_regs (
		.core_clk(core_clk), .rst_n(rst_n), .factory_init_n(factory_init_n),
		.addr_pins(PINS), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.conv_done(conv_done), .conv_fault(conv_fault), .conv_start(conv_start),
		.result_store(result_store), .in_shutdown(in_shutdown),
		.resolution_sel(resolution_sel), .alert_pin(alert_pin), .nv_busy_flag(nv_busy_flag));

	// =================================================================
	// Shared tasks
	task automatic results();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check_bit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ptr, input int n, input logic [15:0] d, output logic ack);
		i_temp_bus_host.start();
		i_temp_bus_host.send({DEV_ADDR_HI, PINS, 1'b0}, ack);
		i_temp_bus_host.send(ptr, ack);
		if (n > 0) i_temp_bus_host.send(d[15:8], ack);
		if (n > 1) i_temp_bus_host.send(d[7:0], ack);
		i_temp_bus_host.stop();
	endtask
	task automatic rd(input logic setp, input logic [7:0] ptr, output logic [15:0] d);
		logic ack;
		if (setp) begin
			i_temp_bus_host.start();
			i_temp_bus_host.send({DEV_ADDR_HI, PINS, 1'b0}, ack);
			i_temp_bus_host.send(ptr, ack);
		end
		i_temp_bus_host.start();
		i_temp_bus_host.send({DEV_ADDR_HI, PINS, 1'b1}, ack);
		i_temp_bus_host.recv(1'b0, d[15:8]);
		i_temp_bus_host.recv(1'b1, d[7:0]);
		i_temp_bus_host.stop();
	endtask
	// Host polls busy before touching stored registers
	task automatic wait_idle();
		int n;
		n = 0;
		while (nv_busy_flag !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 3000) begin
			check_bit("nv_busy_flag", 1'b0, nv_busy_flag);
			results();
		end
	endtask
	task automatic conv(input logic f);
		@(negedge core_clk);
		conv_done = 1'b1;
		conv_fault = f;
		@(negedge core_clk);
		conv_done = 1'b0;
		conv_fault = 1'b0;
		repeat (6) @(negedge core_clk);
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
	endtask

	// =================================================================
	// Scenarios
	task automatic sc_fault_queue();
		int th [4];
		int s0;
		logic ack;
		th = '{1, 2, 4, 6};
		for (int c = 0; c < 4; c++) begin
			wr(PTR_WORK_CFG, 1, {3'b000, 2'(c), 11'h000}, ack);
			repeat (th[c] - 1) conv(1'b1);
			wr(PTR_WORK_CFG, 1, {3'b000, 2'(c), 11'h000}, ack);
			repeat (th[c] - 1) conv(1'b1);
			check_bit("alert_pin", 1'b1, alert_pin);
			conv(1'b1);
			check_bit("alert_pin", 1'b0, alert_pin);
			conv(1'b0);
			check_bit("alert_pin", 1'b1, alert_pin);
		end
		s0 = starts;
		conv(1'b0);
		check_word("conv_starts", 16'(s0 + 1), 16'(starts));
	endtask
	task automatic sc_modes();
		logic ack;
		logic [15:0] d;
		wr(PTR_WORK_CFG, 1, 16'h0400, ack);
		check_bit("alert_pin", 1'b0, alert_pin);
		conv(1'b1);
		check_bit("alert_pin", 1'b1, alert_pin);
		conv(1'b0);
		wr(PTR_WORK_CFG, 1, 16'h0200, ack);
		conv(1'b1);
		conv(1'b0);
		check_bit("alert_pin", 1'b0, alert_pin);
		rd(1'b1, PTR_WORK_CFG, d);
		check_word("working", 16'h0200, d);
		check_bit("sda_out", 1'b0, sda_out);
		check_bit("alert_pin", 1'b1, alert_pin);
	endtask
	task automatic sc_stored();
		logic ack;
		logic [15:0] d;
		wr(PTR_STORED_CFG, 1, 16'h5f00, ack);
		check_bit("nv_busy_flag", 1'b0, nv_busy_flag);
		i_temp_bus_host.start();
		i_temp_bus_host.send({DEV_ADDR_HI, PINS, 1'b0}, ack);
		i_temp_bus_host.send(PTR_STORED_CFG, ack);
		i_temp_bus_host.send(8'h5f, ack);
		i_temp_bus_host.send(8'h00, ack);
		rd(1'b1, PTR_STORED_CFG, d);
		check_word("stored", 16'h0000, d);
		wr(PTR_STORED_CFG, 2, 16'h5f00, ack);
		check_bit("nv_busy_flag", 1'b1, nv_busy_flag);
		rd(1'b0, 8'h00, d);
		check_word("busy_read", 16'hffff, d);
		wr(PTR_STORED_CFG, 2, 16'h0000, ack);
		check_bit("data_ack", 1'b0, ack);
		wr(CMD_COPY_FROM_NV, 0, 16'h0000, ack);
		wait_idle();
		rd(1'b1, PTR_STORED_CFG, d);
		check_word("stored", 16'h5f00, d);
		rd(1'b1, PTR_WORK_CFG, d);
		check_word("working", 16'h0200, d);
		wr(CMD_COPY_FROM_NV, 0, 16'h0000, ack);
		rd(1'b1, PTR_WORK_CFG, d);
		check_word("working", 16'h5f00, d);
		starts = 0;
		do_reset();
		repeat (20) @(negedge core_clk);
		check_bit("in_shutdown", 1'b1, in_shutdown);
		check_word("conv_starts", 16'h0000, 16'(starts));
		check_word("resolution_sel", 16'h0002, {14'h0000, resolution_sel});
		rd(1'b1, PTR_WORK_CFG, d);
		check_word("working", 16'h5f00, d);
		wr(PTR_WORK_CFG, 1, 16'h5e00, ack);
		repeat (4) @(negedge core_clk);
		check_bit("in_shutdown", 1'b0, in_shutdown);
		check_bit("conv_start_seen", 1'b1, starts > 0);
		wr(PTR_WORK_CFG, 1, 16'h5f00, ack);
		check_bit("in_shutdown", 1'b0, in_shutdown);
		conv(1'b0);
		check_bit("in_shutdown", 1'b1, in_shutdown);
	endtask
	task automatic sc_lock();
		logic ack;
		logic [15:0] d;
		wr(PTR_STORED_CFG, 2, 16'hfffb, ack);
		wait_idle();
		rd(1'b1, PTR_STORED_CFG, d);
		check_word("stored", 16'h7f02, d);
		wr(PTR_WORK_CFG, 1, 16'h0000, ack);
		rd(1'b1, PTR_WORK_CFG, d);
		check_word("working", 16'h5f00, d);
		wr(PTR_STORED_CFG, 2, 16'h0000, ack);
		wait_idle();
		rd(1'b1, PTR_STORED_CFG, d);
		check_word("stored", 16'h7f00, d);
		wr(PTR_STORED_CFG, 2, 16'h0004, ack);
		wait_idle();
		wr(PTR_WORK_CFG, 1, 16'h0000, ack);
		rd(1'b1, PTR_WORK_CFG, d);
		check_word("working", 16'h5f00, d);
		wr(PTR_STORED_CFG, 2, 16'h0000, ack);
		wait_idle();
		do_reset();
		rd(1'b1, PTR_STORED_CFG, d);
		check_word("stored", 16'h0004, d);
	endtask

	initial begin
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		factory_init_n = 1'b1;
		repeat (4) @(negedge core_clk);
		sc_fault_queue();
		sc_modes();
		sc_stored();
		sc_lock();
		results();
	end
endmodule

// ==== temp_sensor_config_regs_sva.sv ====
// Purpose: Concurrent checks on the configuration block pins
// Assumes: One core_clk domain, synchronous active-low reset
// Notes:   Bound to the top module below
`timescale 1ns/1ps
module temp_cfg_checker #(
	parameter int PROG_CYCLES = 1000
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic result_store,
	input wire logic in_shutdown,
	input wire logic nv_busy_flag
);
	// =================================================================
	// Helper logic
	logic [31:0] busy_cnt_reg;
	always_ff @(posedge core_clk) begin
		if (!rst_n || !nv_busy_flag)
			busy_cnt_reg <= 32'h0;
		else
			busy_cnt_reg <= busy_cnt_reg + 32'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// =================================================================
	// Assertions
	a_store_after_done: assert property (conv_done && !in_shutdown |=> result_store)
		else $error("result_store missing after conv_done");
	a_halt_after_store: assert property (result_store && !conv_start |-> ##[0:1] in_shutdown)
		else $error("no halt after last result");
	a_halt_quiet: assert property (in_shutdown ##1 in_shutdown |-> !result_store)
		else $error("result stored while halted");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conv_start longer than one cycle");
	a_busy_hold: assert property ($rose(nv_busy_flag) |=> nv_busy_flag [*8])
		else $error("busy dropped early");
	a_busy_length: assert property ($fell(nv_busy_flag) |-> busy_cnt_reg == PROG_CYCLES)
		else $error("busy length wrong");
	a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda_oe changed while scl high");
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !nv_busy_flag && !conv_start && !result_store && in_shutdown)
		else $error("outputs not at reset values");
	c_busy_done: cover property ($fell(nv_busy_flag));
	c_halt: cover property ($rose(in_shutdown));
	c_ack: cover property ($rose(sda_oe));
endmodule

bind temp_sensor_config_regs temp_cfg_checker #(.PROG_CYCLES(PROG_CYCLES)) i_temp_cfg_checker (
	.core_clk     (core_clk),
	.rst_n        (rst_n),
	.scl_in       (scl_in),
	.sda_oe       (sda_oe),
	.conv_done    (conv_done),
	.conv_start   (conv_start),
	.result_store (result_store),
	.in_shutdown  (in_shutdown),
	.nv_busy_flag (nv_busy_flag)
);
